// File: hdl/ubg_pkg.sv
// How it works
// R01 - fifo on: block bit picks block mode
// R02 - single mode: rx ready low while data held
// R03 - block: rx ready falls on trigger/timeout
// R04 - single fifo: tx ready low when fifo empty
// R05 - block: tx ready high only when full
// R06 - plain tx interrupt follows holding/trigger state
// R07 - half duplex: tx interrupt waits for empty (fifo on: also high below trigger with data)
// R08 - rx interrupt high on byte or trigger
// R09 - bus works without any oscillator edge
// R10 - prescaler divides by 1 or 4, strap
// R11 - 16-bit divisor 1..65535 from two bytes
// R12 - divisor resets to low 01, high 00
// R13 - sampling bit picks 16x or 8x
// R14 - tx and rx run on sampling ticks
// R15 - status shows tx empty and tx space
// R16 - timeout: four characters plus twelve bits
// R17 - new divisor loads at next reload
`default_nettype none
package ubg_pkg;
  // --------------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_DIVISOR   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h10;
  // --------------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------------
  localparam int          CTRL_FIFO_EN   = 0;
  localparam int          CTRL_BLOCK     = 3;
  localparam int          CTRL_HALF_DUP  = 4;
  localparam int          CTRL_SAMPLE16  = 5;
  localparam int          CTRL_PRESCALE  = 7;
  localparam int          CTRL_WLEN_LO   = 8;
  localparam logic [9:0]  CTRL_RST       = 10'h020;
  localparam logic [9:0]  CTRL_WMASK     = 10'h3b9;
  // --------------------------------------------------------------------
  // divisor: low byte [7:0], high byte [15:8]
  // --------------------------------------------------------------------
  localparam logic [7:0]  DIV_LOW_RST    = 8'h01;
  localparam logic [7:0]  DIV_HIGH_RST   = 8'h00;
  // --------------------------------------------------------------------
  // status and interrupt bits
  // --------------------------------------------------------------------
  localparam int          ST_TX_SPACE    = 5;
  localparam int          ST_TX_EMPTY    = 6;
  localparam int          IRQ_TIMEOUT    = 0;
  localparam int          IRQ_RX_TRIG    = 1;
  localparam int          IRQ_TX_EMPTY   = 2;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam logic [3:0]  SAMPLES_16X    = 4'hf;
  localparam logic [3:0]  SAMPLES_8X     = 4'h7;
  localparam logic [1:0]  PRESCALE_DIV4  = 2'h3;
  localparam logic [1:0]  STRAP_WAIT     = 2'h2;
  localparam logic [5:0]  TIMEOUT_CHARS  = 6'h04;
  localparam logic [5:0]  TIMEOUT_BITS   = 6'h0c;
  localparam logic [5:0]  WLEN_BASE      = 6'h05;
  // bus sequencer states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } ubg_bus_type;
endpackage
`default_nettype wire

// File: hdl/ubg_top.sv
`default_nettype none
module ubg_top #(
  parameter int FIFO_DEPTH = 64,
  parameter int CNT_W      = $clog2(FIFO_DEPTH + 1)
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              osc_in,
  input  wire logic              prescale_select_pin,
  input  wire logic [CNT_W-1:0]  rx_count,
  input  wire logic [CNT_W-1:0]  tx_count,
  input  wire logic              rx_above_trig,
  input  wire logic              tx_above_trig,
  input  wire logic              tsr_empty,
  input  wire logic              rx_byte_in,
  output logic                   rx_ready_n,
  output logic                   tx_ready_n,
  output logic                   irq_out_chan_a,
  output logic                   sample_tick,
  output logic                   bit_tick,
  output logic                   irq
);
  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                    osc_s1;
    logic                    osc_s2;
    logic                    osc_prev;
    logic                    sel_s1;
    logic                    sel_s2;
    logic [1:0]              strap_cnt;
    logic                    strap_done;
    logic [9:0]              ctrl;
    logic [15:0]             divisor;
    logic [1:0]              pre_cnt;
    logic [15:0]             div_cnt;
    logic [3:0]              samp_cnt;
    logic [5:0]              tout_cnt;
    logic                    timeout;
    logic                    rx_blk;
    logic                    rx_trig_prev;
    logic                    tx_empty_prev;
    logic [2:0]              irq_stat;
    logic [2:0]              irq_mask;
    ubg_pkg::ubg_bus_type    bus_st;
    logic                    wr_pend;
    logic [7:0]              a_addr;
    logic [31:0]             hrdata;
    logic                    hreadyout;
    logic                    hresp;
    logic                    rx_ready_n;
    logic                    tx_ready_n;
    logic                    irq_pin;
    logic                    sample_tick;
    logic                    bit_tick;
    logic                    irq;
  } ubg_state_type;

  ubg_state_type s_ff;
  ubg_state_type nxt_s;

  logic        fifo_on;
  logic        blk_on;
  logic        tx_empty_all;
  logic        tx_int;
  logic        rx_int;
  logic        accept;
  logic        pre_tick;
  logic [5:0]  tout_limit;
  logic [2:0]  events;
  logic [2:0]  w1c;
  logic [31:0] rd_val;

  // --------------------------------------------------------------------
  // pin decode from the current mode
  // --------------------------------------------------------------------
  assign fifo_on      = s_ff.ctrl[ubg_pkg::CTRL_FIFO_EN];
  assign blk_on       = fifo_on & s_ff.ctrl[ubg_pkg::CTRL_BLOCK];          // R01
  assign tx_empty_all = (tx_count == '0) & tsr_empty;
  assign accept       = hsel & htrans[1] & hready;
  // four characters of (5 + wlen) bits plus the fixed tail
  assign tout_limit   = 6'((ubg_pkg::WLEN_BASE
                        + 6'(s_ff.ctrl[ubg_pkg::CTRL_WLEN_LO +: 2]))
                        * ubg_pkg::TIMEOUT_CHARS + ubg_pkg::TIMEOUT_BITS);  // R16

  // transmit and receive halves of the interrupt pin
  always_comb begin
    if (s_ff.ctrl[ubg_pkg::CTRL_HALF_DUP]) begin
      // half duplex waits until the line can be turned round, or with the fifo on until data sits below trigger
      tx_int = fifo_on ? ((!tx_above_trig && tx_count != '0) || tx_empty_all)
                       : tx_empty_all;                                     // R07
    end else begin
      tx_int = fifo_on ? !tx_above_trig : (tx_count == '0);                // R06
    end
    rx_int = fifo_on ? rx_above_trig : (rx_count != '0);                   // R08
  end

  // readback of every mapped register, zero elsewhere
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_ff.a_addr)
      ubg_pkg::ADDR_CTRL:     rd_val[9:0]  = s_ff.ctrl;
      ubg_pkg::ADDR_DIVISOR:  rd_val[15:0] = s_ff.divisor;
      ubg_pkg::ADDR_STATUS: begin
        rd_val[0] = s_ff.rx_ready_n;
        rd_val[1] = s_ff.tx_ready_n;
        rd_val[2] = s_ff.irq_pin;
        rd_val[3] = s_ff.timeout;
        rd_val[4] = s_ff.ctrl[ubg_pkg::CTRL_PRESCALE];
        rd_val[ubg_pkg::ST_TX_SPACE] = tx_count != CNT_W'(FIFO_DEPTH);     // R15
        rd_val[ubg_pkg::ST_TX_EMPTY] = tx_empty_all;                       // R15
      end
      ubg_pkg::ADDR_IRQ_STAT: rd_val[2:0]  = s_ff.irq_stat;
      ubg_pkg::ADDR_IRQ_MASK: rd_val[2:0]  = s_ff.irq_mask;
      default:                rd_val       = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    nxt_s       = s_ff;
    pre_tick    = 1'b0;
    events      = 3'h0;
    w1c         = 3'h0;
    // oscillator is a foreign clock: two flops, then edge detect
    nxt_s.osc_s1   = osc_in;
    nxt_s.osc_s2   = s_ff.osc_s1;
    nxt_s.osc_prev = s_ff.osc_s2;
    nxt_s.sel_s1   = prescale_select_pin;
    nxt_s.sel_s2   = s_ff.sel_s1;
    nxt_s.hresp    = 1'b0;

    // strap caught once the synchroniser has settled after release
    if (s_ff.strap_cnt != ubg_pkg::STRAP_WAIT) begin
      nxt_s.strap_cnt = s_ff.strap_cnt + 2'h1;
    end else if (!s_ff.strap_done) begin
      nxt_s.strap_done                    = 1'b1;
      nxt_s.ctrl[ubg_pkg::CTRL_PRESCALE]  = s_ff.sel_s2;                   // R10
    end

    // bus write data phase; runs with or without oscillator edges
    if (s_ff.wr_pend) begin                                                // R09
      case (s_ff.a_addr)
        ubg_pkg::ADDR_CTRL: begin
          nxt_s.ctrl = (s_ff.ctrl & ~ubg_pkg::CTRL_WMASK)
                     | (hwdata[9:0] & ubg_pkg::CTRL_WMASK);               // R10
        end
        ubg_pkg::ADDR_DIVISOR:  nxt_s.divisor  = hwdata[15:0];             // R11
        ubg_pkg::ADDR_IRQ_STAT: w1c            = hwdata[2:0];
        ubg_pkg::ADDR_IRQ_MASK: nxt_s.irq_mask = hwdata[2:0];
        default:                w1c            = 3'h0;
      endcase
    end
    nxt_s.wr_pend = 1'b0;

    // address phase; reads take one wait state so data comes from a flop
    case (s_ff.bus_st)
      ubg_pkg::BUS_IDLE: begin
        if (accept) begin
          nxt_s.a_addr = haddr[7:0];
          if (hwrite) begin
            nxt_s.wr_pend = 1'b1;
          end else begin
            nxt_s.bus_st    = ubg_pkg::BUS_READ;
            nxt_s.hreadyout = 1'b0;
          end
        end
      end
      ubg_pkg::BUS_READ: begin
        nxt_s.hrdata    = rd_val;
        nxt_s.hreadyout = 1'b1;
        nxt_s.bus_st    = ubg_pkg::BUS_IDLE;
      end
      default: begin
        nxt_s.bus_st    = ubg_pkg::BUS_IDLE;
        nxt_s.hreadyout = 1'b1;
      end
    endcase

    // prescaler: every edge, or one edge in four
    if (s_ff.osc_s2 && !s_ff.osc_prev) begin
      if (s_ff.pre_cnt == 2'h0) begin
        pre_tick      = 1'b1;
        nxt_s.pre_cnt = s_ff.ctrl[ubg_pkg::CTRL_PRESCALE]
                      ? ubg_pkg::PRESCALE_DIV4 : 2'h0;                     // R10
      end else begin
        nxt_s.pre_cnt = s_ff.pre_cnt - 2'h1;
      end
    end

    // divisor counter; the register is only sampled at reload, so a
    // rewrite mid-period never shortens the current sampling period
    nxt_s.sample_tick = 1'b0;
    nxt_s.bit_tick    = 1'b0;
    if (pre_tick) begin
      if (s_ff.div_cnt <= 16'h0001) begin
        nxt_s.div_cnt     = (s_ff.divisor == 16'h0000) ? 16'h0001
                                                       : s_ff.divisor;    // R17
        nxt_s.sample_tick = 1'b1;                                          // R11
      end else begin
        nxt_s.div_cnt = s_ff.div_cnt - 16'h0001;
      end
    end

    // bit clock for the shifters: 16 or 8 samples per bit
    if (nxt_s.sample_tick) begin                                           // R14
      if (s_ff.samp_cnt == 4'h0) begin
        nxt_s.bit_tick = 1'b1;
        nxt_s.samp_cnt = s_ff.ctrl[ubg_pkg::CTRL_SAMPLE16]
                       ? ubg_pkg::SAMPLES_16X : ubg_pkg::SAMPLES_8X;       // R13
      end else begin
        nxt_s.samp_cnt = s_ff.samp_cnt - 4'h1;
      end
    end

    // receive time-out counted in bit times since the last byte
    if (rx_byte_in || rx_count == '0) begin
      nxt_s.tout_cnt = 6'h00;
      nxt_s.timeout  = 1'b0;
    end else if (s_ff.bit_tick && !s_ff.timeout) begin
      nxt_s.tout_cnt = s_ff.tout_cnt + 6'h01;
      if (s_ff.tout_cnt + 6'h01 >= tout_limit) begin
        nxt_s.timeout = 1'b1;                                              // R16
        events[ubg_pkg::IRQ_TIMEOUT] = 1'b1;
      end
    end

    // block-mode receive latch: armed by trigger or timeout, freed on empty
    if (rx_count == '0) begin
      nxt_s.rx_blk = 1'b0;                                                 // R03
    end else if (rx_above_trig || s_ff.timeout) begin
      nxt_s.rx_blk = 1'b1;                                                 // R03
    end

    // pins, registered
    nxt_s.rx_ready_n = blk_on ? !nxt_s.rx_blk : (rx_count == '0);          // R02
    nxt_s.tx_ready_n = blk_on ? (tx_count == CNT_W'(FIFO_DEPTH))           // R05
                              : (tx_count != '0);                          // R04
    nxt_s.irq_pin    = tx_int | rx_int;

    // sticky events; a set in the clearing cycle wins
    nxt_s.rx_trig_prev  = rx_above_trig;
    nxt_s.tx_empty_prev = tx_empty_all;
    events[ubg_pkg::IRQ_RX_TRIG]  = rx_above_trig & ~s_ff.rx_trig_prev;
    events[ubg_pkg::IRQ_TX_EMPTY] = tx_empty_all & ~s_ff.tx_empty_prev;
    nxt_s.irq_stat = (s_ff.irq_stat & ~w1c) | events;
    nxt_s.irq      = |(nxt_s.irq_stat & nxt_s.irq_mask);
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff             <= '0;
      s_ff.ctrl        <= ubg_pkg::CTRL_RST;
      s_ff.divisor     <= {ubg_pkg::DIV_HIGH_RST, ubg_pkg::DIV_LOW_RST};   // R12
      s_ff.div_cnt     <= 16'h0001;
      s_ff.irq_mask    <= ubg_pkg::IRQ_MASK_RST;
      s_ff.bus_st      <= ubg_pkg::BUS_IDLE;
      s_ff.hreadyout   <= 1'b1;
      s_ff.rx_ready_n  <= 1'b1;
      s_ff.tx_ready_n  <= 1'b0;
      s_ff.tx_empty_prev <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hrdata         = s_ff.hrdata;
  assign hreadyout      = s_ff.hreadyout;
  assign hresp          = s_ff.hresp;
  assign rx_ready_n     = s_ff.rx_ready_n;
  assign tx_ready_n     = s_ff.tx_ready_n;
  assign irq_out_chan_a = s_ff.irq_pin;
  assign sample_tick    = s_ff.sample_tick;
  assign bit_tick       = s_ff.bit_tick;
  assign irq            = s_ff.irq;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // pins register one edge late, so each check looks one edge after its cause
  chk_rx_ready_n_single: assert property (!blk_on |=> rx_ready_n == ($past(rx_count) == '0)) // R02
    else $error("rx ready wrong in single mode");
  chk_rx_ready_n_block: assert property (blk_on && rx_count != '0 && rx_above_trig // R03
                                    |=> !rx_ready_n)
    else $error("rx ready not low at trigger");
  chk_rx_ready_n_empty: assert property (blk_on && rx_count == '0 |=> rx_ready_n) // R03
    else $error("rx ready not high when empty");
  chk_tx_ready_n_single: assert property (!blk_on |=> tx_ready_n == ($past(tx_count) != '0)) // R04
    else $error("tx ready wrong in single mode");
  chk_tx_ready_n_block: assert property (blk_on |=> tx_ready_n // R05
                                    == ($past(tx_count) == CNT_W'(FIFO_DEPTH)))
    else $error("tx ready wrong in block mode");
  chk_irq_pin_rx: assert property (fifo_on && rx_above_trig |=> irq_out_chan_a) // R08
    else $error("rx interrupt pin not high");
  chk_irq_pin_hd: assert property (s_ff.ctrl[ubg_pkg::CTRL_HALF_DUP] && !fifo_on // R07
                                   && !tx_empty_all && rx_count == '0 |=> !irq_out_chan_a)
    else $error("half duplex interrupt early");
  chk_irq_pin_plain: assert property (!s_ff.ctrl[ubg_pkg::CTRL_HALF_DUP] && !fifo_on // R06
                                      && tx_count == '0 |=> irq_out_chan_a)
    else $error("tx interrupt pin not high");
  chk_read_wait: assert property (accept && !hwrite && s_ff.bus_st == ubg_pkg::BUS_IDLE // R09
                                  |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");
  // a 16x bit spans sixteen sample ticks, each several clocks apart
  chk_bit_spacing: assert property (bit_tick && s_ff.ctrl[ubg_pkg::CTRL_SAMPLE16] // R13
                                    |=> !bit_tick[*8])
    else $error("bit ticks too close");
  // a running count only steps down, whatever software writes meanwhile
  chk_div_hold: assert property (pre_tick && s_ff.div_cnt > 16'h0001 // R17
                                 |=> s_ff.div_cnt == $past(s_ff.div_cnt) - 16'h0001)
    else $error("divisor loaded mid period");
  chk_timeout_pin: assert property (blk_on && s_ff.timeout && rx_count != '0 // R03
                                    |=> !rx_ready_n)
    else $error("rx ready not low after time-out");

  // main scenarios the bench is expected to reach
  cov_block_timeout: cover property (blk_on && s_ff.timeout ##1 !rx_ready_n);
  cov_bit_tick:      cover property (bit_tick);
  cov_irq_out:       cover property (irq);
  cov_div4_tick:     cover property (sample_tick && s_ff.ctrl[ubg_pkg::CTRL_PRESCALE]);
  cov_hd_fifo_irq:   cover property (fifo_on && s_ff.ctrl[ubg_pkg::CTRL_HALF_DUP] && tx_int);
endmodule
`default_nettype wire

// File: testbench/ubg_far_model.sv
`default_nettype none
// ----------------------------------------------------------------------
// far side: fifo occupancy, shift register state and oscillator
// ----------------------------------------------------------------------
module ubg_far_model #(
  parameter int CNT_W    = 7,
  parameter int RX_TRIG  = 4,
  parameter int TX_TRIG  = 8,
  parameter int OSC_HALF = 4
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             osc_stop,
  input  wire logic             rx_add,
  input  wire logic             rx_clear,
  input  wire logic [CNT_W-1:0] tx_load,
  input  wire logic             tsr_busy,
  output logic                  osc_in,
  output logic      [CNT_W-1:0] rx_count,
  output logic      [CNT_W-1:0] tx_count,
  output logic                  rx_above_trig,
  output logic                  tx_above_trig,
  output logic                  tsr_empty,
  output logic                  rx_byte_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] osc_cnt;
  // oscillator derived from hclk so tick spacing is exact; it may be stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt    <= 8'h00;
      osc_in     <= 1'b0;
      rx_count   <= '0;
      tx_count   <= '0;
      tsr_empty  <= 1'b1;
      rx_byte_in <= 1'b0;
    end else begin
      if (!osc_stop) begin
        osc_cnt <= (osc_cnt == 8'(OSC_HALF - 1)) ? 8'h00 : osc_cnt + 8'h01;
        if (osc_cnt == 8'(OSC_HALF - 1)) begin
          osc_in <= !osc_in;
        end
      end
      // a received byte lands in the fifo together with its strobe
      if (rx_clear) begin
        rx_count <= '0;
      end else if (rx_add) begin
        rx_count <= rx_count + 1'b1;
      end
      rx_byte_in <= rx_add;
      tx_count   <= tx_load;
      tsr_empty  <= !tsr_busy;
    end
  end
  // trigger comparators: rx at or above, tx strictly above
  assign rx_above_trig = rx_count >= CNT_W'(RX_TRIG);
  assign tx_above_trig = tx_count > CNT_W'(TX_TRIG);
endmodule
`default_nettype wire

// File: testbench/uart_ready_irq_pins_baud_gen_test.sv
`default_nettype none
module uart_ready_irq_pins_baud_gen_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CNT_W = 7;
  logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic             osc_in, prescale_select_pin, osc_stop, rx_add, rx_clear, tsr_busy;
  logic [CNT_W-1:0] rx_count, tx_count, tx_load;
  logic             rx_above_trig, tx_above_trig, tsr_empty, rx_byte_in;
  logic             rx_ready_n, tx_ready_n, irq_out_chan_a, sample_tick, bit_tick, irq;
  int               err_total, cmp_count, cyc;
  logic [9:0]       ctl [4] = '{10'h021, 10'h001, 10'h0a1, 10'h001};
  logic [15:0]      dv [4]  = '{16'h0002, 16'h0003, 16'h0001, 16'h0102};
  assign hready = hreadyout;
  ubg_top u_ubg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_in(osc_in),
    .prescale_select_pin(prescale_select_pin), .rx_count(rx_count), .tx_count(tx_count),
    .rx_above_trig(rx_above_trig), .tx_above_trig(tx_above_trig), .tsr_empty(tsr_empty),
    .rx_byte_in(rx_byte_in), .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n),
    .irq_out_chan_a(irq_out_chan_a), .sample_tick(sample_tick), .bit_tick(bit_tick),
    .irq(irq));
  ubg_far_model u_ubg_far_model (.hclk(hclk), .hresetn(hresetn), .osc_stop(osc_stop),
    .rx_add(rx_add), .rx_clear(rx_clear), .tx_load(tx_load), .tsr_busy(tsr_busy),
    .osc_in(osc_in), .rx_count(rx_count), .tx_count(tx_count),
    .rx_above_trig(rx_above_trig), .tx_above_trig(tx_above_trig),
    .tsr_empty(tsr_empty), .rx_byte_in(rx_byte_in));
  // ----------------------------------------------------------------------
  // clock and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic final_report();
    $display("checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rcheck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd & m, e);
    check({31'h0, hresp}, 32'h0);
  endtask
  // model outputs register once, pins one edge later
  task automatic pins(input logic [2:0] e);
    repeat (3) @(posedge hclk);
    check({29'h0, rx_ready_n, tx_ready_n, irq_out_chan_a}, {29'h0, e});
  endtask
  task automatic add_rx(input int n);
    repeat (n) begin
      rx_add <= 1'b1;
      @(posedge hclk);
      rx_add <= 1'b0;
      @(posedge hclk);
    end
  endtask
  task automatic tick_wait(input logic use_bit);
    cyc = 0;
    do begin
      @(posedge hclk);
      cyc++;
    end while ((use_bit ? bit_tick : sample_tick) !== 1'b1 && cyc < 20000);
    if (cyc >= 20000) begin
      err_total++;
      final_report();
    end
  endtask
  // spacing of a full tick period, skipping the partial one after a change
  task automatic gap(input logic use_bit, input int e);
    repeat (3) tick_wait(use_bit);
    check(32'(cyc), 32'(e));
  endtask
  task automatic do_reset(input logic strap);
    hresetn             <= 1'b0;
    prescale_select_pin <= strap;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {hsel, hwrite, osc_stop, rx_add, rx_clear, tsr_busy, prescale_select_pin} = '0;
    {haddr, hwdata, htrans, hsize, tx_load, err_total, cmp_count} = '0;
    hresetn = 1'b0;
    @(posedge hclk);
    hsize    <= 3'h2;
    osc_stop <= 1'b1;
    do_reset(1'b0);
    // registers with the oscillator stopped
    rcheck(8'h00, 32'hffffffff, 32'h020);
    rcheck(8'h04, 32'hffffffff, 32'h0001);
    rcheck(8'h08, 32'h7f, 32'h65);
    rcheck(8'h10, 32'hffffffff, 32'h0);
    bus(1'b1, 8'h14, 32'hff);
    rcheck(8'h14, 32'hffffffff, 32'h0);
    osc_stop <= 1'b0;
    // fifo off: holding register behaviour, plain and half duplex
    tsr_busy <= 1'b1;
    pins(3'b101);
    tx_load <= 7'd1;
    pins(3'b110);
    add_rx(1);
    pins(3'b011);
    rx_clear <= 1'b1;
    @(posedge hclk);
    rx_clear <= 1'b0;
    pins(3'b110);
    bus(1'b1, 8'h00, 32'h030);
    tx_load <= 7'd0;
    pins(3'b100);
    tsr_busy <= 1'b0;
    pins(3'b101);
    // half duplex with the fifo on: below trigger but not empty raises it
    bus(1'b1, 8'h00, 32'h031);
    tsr_busy <= 1'b1;
    pins(3'b100);
    tx_load <= 7'd5;
    pins(3'b111);
    tx_load  <= 7'd0;
    tsr_busy <= 1'b0;
    // fifo on, single character mode
    bus(1'b1, 8'h00, 32'h021);
    tx_load <= 7'd10;
    pins(3'b110);
    tx_load <= 7'd5;
    pins(3'b111);
    tx_load <= 7'd0;
    pins(3'b101);
    add_rx(1);
    pins(3'b001);
    rx_clear <= 1'b1;
    @(posedge hclk);
    rx_clear <= 1'b0;
    // block mode
    bus(1'b1, 8'h00, 32'h029);
    tx_load <= 7'd63;
    pins(3'b100);
    tx_load <= 7'd64;
    pins(3'b110);
    rcheck(8'h08, 32'h60, 32'h00);
    tx_load <= 7'd0;
    pins(3'b101);
    rcheck(8'h08, 32'h60, 32'h60);
    add_rx(3);
    pins(3'b101);
    add_rx(1);
    pins(3'b001);
    rx_clear <= 1'b1;
    @(posedge hclk);
    rx_clear <= 1'b0;
    pins(3'b101);
    // interrupt: sticky status, mask, write one to clear
    bus(1'b1, 8'h0c, 32'h7);
    tx_load <= 7'd5;
    repeat (4) @(posedge hclk);
    tx_load <= 7'd0;
    repeat (4) @(posedge hclk);
    rcheck(8'h0c, 32'h4, 32'h4);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h10, 32'h4);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h0c, 32'h4);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    rcheck(8'h0c, 32'h4, 32'h0);
    // receive time-out: 8x, divisor 1, five-bit words gives 4*5+12 bits
    bus(1'b1, 8'h00, 32'h009);
    bus(1'b1, 8'h0c, 32'h7);
    add_rx(1);
    repeat (30) tick_wait(1'b1);
    rcheck(8'h0c, 32'h1, 32'h0);
    check({31'h0, rx_ready_n}, 32'h1);
    repeat (4) tick_wait(1'b1);
    rcheck(8'h0c, 32'h1, 32'h1);
    check({31'h0, rx_ready_n}, 32'h0);
    rcheck(8'h08, 32'h18, 32'h08);
    rx_clear <= 1'b1;
    @(posedge hclk);
    rx_clear <= 1'b0;
    // generator: prescaler, 16-bit divisor and sampling mode
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, {22'h0, ctl[i]});
      bus(1'b1, 8'h04, {16'h0, dv[i]});
      gap(1'b0, 8 * (ctl[i][7] ? 4 : 1) * int'(dv[i]));
      if (i < 3) begin
        gap(1'b1, 8 * (ctl[i][7] ? 4 : 1) * int'(dv[i]) * (ctl[i][5] ? 16 : 8));
      end
    end
    // strap picks divide by four after a second reset
    do_reset(1'b1);
    rcheck(8'h00, 32'hffffffff, 32'h0a0);
    rcheck(8'h08, 32'h10, 32'h10);
    rcheck(8'h04, 32'hffffffff, 32'h0001);
    gap(1'b0, 32);
    final_report();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge hclk);
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
